/* hdl/psc_ctrl.sv */
`timescale 1ns/100ps
// Behaviour
// - Address captured on rising edge selects location.
// - Inputs captured rising edge; qualifier high ignored.
// - Edge counts only with qualifier sampled low.
// - Write strobe sampled only on recognized edges.
// - Low lane select with strobe writes lane.
// - Advance high steps the burst counter.
// - Advance low loads presented address.
// - Three chip selects combine into selection.
// - Qualifier high holds state, no deselect.
// - Data lanes released on write, emerge, deselect.
// - Strap high interleaved, low linear order.
module psc_ctrl (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clock_qualifier_n,
  input wire psc_pkg::psc_ctrl_t ctrl,
  input wire logic burst_order_strap,
  input wire logic output_drive_enable_n,
  input wire logic [psc_pkg::DATA_W-1:0] data_lane_bits_in,
  input wire logic [psc_pkg::LANES-1:0] parity_lane_bits_in,
  output psc_pkg::psc_write_t write_req,
  output logic write_valid,
  output logic [psc_pkg::ADDR_W-1:0] read_address,
  output logic read_valid,
  output logic selected,
  output logic data_lane_oe,
  output logic interleaved
);

  // ==========================================================================
  // Pin synchronisers and edge qualification
  // ==========================================================================
  // The static strap is asynchronous to clk, so it passes three flops.
  logic [2:0] strap_sync_q;
  logic strap_q;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      strap_sync_q <= 3'h7;
    end else begin
      strap_sync_q <= {strap_sync_q[1:0], burst_order_strap};
    end
  end
  // The strap defaults high, matching a floating pin.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      strap_q <= 1'b1;
    end else if (strap_sync_q[2] == strap_sync_q[1]) begin
      strap_q <= strap_sync_q[2];
    end
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      interleaved <= 1'b1;
    end else begin
      interleaved <= strap_q;
    end
  end

  // The bus pins are synchronous to clk and are taken directly.
  logic edge_ok;
  logic sel_now;
  assign edge_ok = !clock_qualifier_n;

  function automatic logic all_selected(input psc_pkg::psc_ctrl_t c);
    return !c.chip_select_one_n && c.chip_select_two && !c.chip_select_three_n;
  endfunction
  assign sel_now = all_selected(ctrl);

  // ==========================================================================
  // Access phase machine
  // ==========================================================================
  psc_pkg::psc_state_t state_q;
  psc_pkg::psc_state_t state_d;
  logic emerge_q;
  always_comb begin
    state_d = state_q;
    if (!sel_now) begin
      state_d = psc_pkg::PSC_DESEL;
    end else if (!ctrl.write_strobe_n) begin
      state_d = psc_pkg::PSC_WRITE;
    end else begin
      state_d = psc_pkg::PSC_READ;
    end
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= psc_pkg::PSC_DESEL;
    end else if (edge_ok) begin
      state_q <= state_d;
    end
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      emerge_q <= 1'b0;
    end else if (edge_ok) begin
      emerge_q <= sel_now && (state_q == psc_pkg::PSC_DESEL);
    end
  end

  // ==========================================================================
  // Address load and burst counter
  // ==========================================================================
  logic [psc_pkg::ADDR_W-1:0] base_q;
  logic [psc_pkg::OFFS_W-1:0] count_q;
  logic [psc_pkg::OFFS_W-1:0] start_q;
  logic [psc_pkg::OFFS_W-1:0] offs;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      base_q <= psc_pkg::ADDR_RST;
      start_q <= psc_pkg::OFFS_RST;
      count_q <= psc_pkg::OFFS_RST;
    end else if (edge_ok) begin
      if (!ctrl.advance_or_load) begin
        base_q <= ctrl.address;
        start_q <= ctrl.address[psc_pkg::OFFS_LSB +: psc_pkg::OFFS_W];
        count_q <= psc_pkg::OFFS_RST;
      end else begin
        count_q <= count_q + 2'h1;
      end
    end
  end
  // Interleaved order flips offset bits; linear order wraps within four.
  assign offs = strap_q ? (start_q ^ count_q) : (start_q + count_q);

  logic [psc_pkg::ADDR_W-1:0] cur_addr;
  always_comb begin
    cur_addr = base_q;
    cur_addr[psc_pkg::OFFS_LSB +: psc_pkg::OFFS_W] = offs;
  end

  // ==========================================================================
  // Write capture and output drive
  // ==========================================================================
  // The write data phase follows the address phase by one edge.
  logic [psc_pkg::LANES-1:0] lanes_q;
  logic wr_pend_q;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      lanes_q <= psc_pkg::LANE_SEL_RST;
      wr_pend_q <= 1'b0;
    end else if (edge_ok) begin
      lanes_q <= ctrl.byte_lane_write_selects;
      wr_pend_q <= sel_now && !ctrl.write_strobe_n;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      write_req <= '0;
      write_valid <= 1'b0;
      read_address <= psc_pkg::ADDR_RST;
      read_valid <= 1'b0;
      selected <= 1'b0;
      data_lane_oe <= 1'b0;
    end else begin
      write_valid <= edge_ok && wr_pend_q;
      read_valid <= edge_ok && state_q == psc_pkg::PSC_READ;
      if (edge_ok) begin
        write_req.address <= cur_addr;
        write_req.lane_enable <= ~lanes_q;
        write_req.data <= data_lane_bits_in;
        write_req.parity <= parity_lane_bits_in;
        read_address <= cur_addr;
        selected <= state_d != psc_pkg::PSC_DESEL;
        // Driving is barred on write, first emerge edge and deselect.
        data_lane_oe <= !output_drive_enable_n && state_q == psc_pkg::PSC_READ
                        && !emerge_q && sel_now && ctrl.write_strobe_n;
      end else begin
        data_lane_oe <= data_lane_oe && !output_drive_enable_n;
      end
    end
  end

  // ==========================================================================
  // Checks
  // ==========================================================================
  chk_hold_when_masked: assert property (@(posedge clk) disable iff (!reset_n)
    clock_qualifier_n |=> $stable(state_q) && $stable(base_q) && $stable(count_q))
    else $error("State moved while the clock qualifier was high.");
  chk_load_address: assert property (@(posedge clk) disable iff (!reset_n)
    edge_ok && !ctrl.advance_or_load |=> base_q == $past(ctrl.address) && count_q == 2'h0)
    else $error("Address was not loaded.");
  chk_advance_count: assert property (@(posedge clk) disable iff (!reset_n)
    edge_ok && ctrl.advance_or_load |=> count_q == $past(count_q) + 2'h1 && $stable(base_q))
    else $error("Burst counter did not advance.");
  chk_deselect_all: assert property (@(posedge clk) disable iff (!reset_n)
    edge_ok && !sel_now |=> state_q == psc_pkg::PSC_DESEL ##1 !data_lane_oe)
    else $error("Inactive chip select did not deselect.");
  chk_write_lanes: assert property (@(posedge clk) disable iff (!reset_n)
    edge_ok && sel_now && !ctrl.write_strobe_n ##1 edge_ok |=>
      write_valid && write_req.lane_enable == ~$past(ctrl.byte_lane_write_selects, 2))
    else $error("Write lanes do not match the lane selects.");
  chk_strobe_masked: assert property (@(posedge clk) disable iff (!reset_n)
    clock_qualifier_n |=> !write_valid)
    else $error("Write issued on an unrecognized edge.");
  chk_write_release: assert property (@(posedge clk) disable iff (!reset_n)
    edge_ok && !ctrl.write_strobe_n |=> !data_lane_oe)
    else $error("Data lanes driven during a write.");
  chk_emerge_release: assert property (@(posedge clk) disable iff (!reset_n)
    edge_ok && state_q == psc_pkg::PSC_DESEL ##1 edge_ok |=> !data_lane_oe)
    else $error("Data lanes driven on the edge after deselect.");
  chk_selected_flag: assert property (@(posedge clk) disable iff (!reset_n)
    edge_ok |=> selected == $past(sel_now))
    else $error("Selection flag disagrees with the chip selects.");
  chk_strap_order: assert property (@(posedge clk) disable iff (!reset_n)
    strap_sync_q[2] == strap_sync_q[1] |=> strap_q == $past(strap_sync_q[2]))
    else $error("Burst order did not follow the strap.");

  cov_write: cover property (@(posedge clk) disable iff (!reset_n) write_valid);
  cov_read_burst: cover property (@(posedge clk) disable iff (!reset_n)
    read_valid ##1 read_valid ##1 read_valid);
  cov_masked_edge: cover property (@(posedge clk) disable iff (!reset_n)
    edge_ok ##1 clock_qualifier_n ##1 edge_ok);
  cov_linear: cover property (@(posedge clk) disable iff (!reset_n) !interleaved && read_valid);

endmodule // psc_ctrl

/* hdl/psc_pkg.sv */
package psc_pkg;

  // ==========================================================================
  // Widths
  // ==========================================================================
  localparam int unsigned ADDR_W = 18;
  localparam int unsigned LANES = 4;
  localparam int unsigned LANE_W = 8;
  localparam int unsigned DATA_W = LANES * LANE_W;
  localparam int unsigned OFFS_W = 2;

  // ==========================================================================
  // Reset values and field positions
  // ==========================================================================
  localparam logic [ADDR_W-1:0] ADDR_RST = 18'h00000;
  localparam logic [OFFS_W-1:0] OFFS_RST = 2'h0;
  localparam logic [LANES-1:0] LANE_SEL_RST = 4'hF;
  localparam int unsigned OFFS_LSB = 0;

  // ==========================================================================
  // Access phase states
  // ==========================================================================
  typedef enum logic [3:0] {
    PSC_IDLE = 4'h1,
    PSC_READ = 4'h2,
    PSC_WRITE = 4'h4,
    PSC_DESEL = 4'h8
  } psc_state_t;

  // Control inputs of one clock edge, as presented on the pins.
  typedef struct packed {
    logic [ADDR_W-1:0] address;
    logic [LANES-1:0] byte_lane_write_selects;
    logic write_strobe_n;
    logic advance_or_load;
    logic chip_select_one_n;
    logic chip_select_two;
    logic chip_select_three_n;
  } psc_ctrl_t;

  // Write request handed to the array.
  typedef struct packed {
    logic [ADDR_W-1:0] address;
    logic [LANES-1:0] lane_enable;
    logic [DATA_W-1:0] data;
    logic [LANES-1:0] parity;
  } psc_write_t;

endpackage

/* testbench/psc_ctrl_model.sv */
`timescale 1ns/100ps
// ============================================================================
// Memory controller model: random traffic, one request per clock edge
// ============================================================================
module psc_ctrl_model (
  input wire logic clk,
  input wire logic run,
  output logic clock_qualifier_n,
  output psc_pkg::psc_ctrl_t ctrl,
  output logic [psc_pkg::DATA_W-1:0] data_out,
  output logic [psc_pkg::LANES-1:0] parity_out
);
  logic burst_ok_q;
  logic ok;
  psc_pkg::psc_ctrl_t c;
  psc_pkg::psc_ctrl_t idle;

  initial begin
    idle = '0;
    idle.chip_select_one_n = 1'b1;
    idle.chip_select_three_n = 1'b1;
    idle.write_strobe_n = 1'b1;
    ctrl = idle;
    clock_qualifier_n = 1'b1;
    burst_ok_q = 1'b0;
    data_out = '0;
    parity_out = '0;
  end

  // Data lines change every cycle, so stale data never looks valid.
  always @(posedge clk) begin
    ok = burst_ok_q;
    if (!clock_qualifier_n) begin
      ok = !ctrl.chip_select_one_n && ctrl.chip_select_two && !ctrl.chip_select_three_n && ctrl.write_strobe_n;
    end
    c = 27'($urandom);
    c.chip_select_one_n = ($urandom % 6 == 0);
    c.chip_select_two = ($urandom % 6 != 0);
    c.chip_select_three_n = ($urandom % 6 == 0);
    c.advance_or_load = ok && $urandom % 2;
    if (c.advance_or_load) begin
      c.chip_select_one_n = 1'b0;
      c.chip_select_two = 1'b1;
      c.chip_select_three_n = 1'b0;
      c.write_strobe_n = 1'b1;
    end
    ctrl <= run ? c : idle;
    clock_qualifier_n <= run ? ($urandom % 4 == 0) : 1'b1;
    burst_ok_q <= run && ok;
    data_out <= $urandom;
    parity_out <= 4'($urandom);
  end
endmodule // psc_ctrl_model

/* testbench/tb_top.sv */
`timescale 1ns/100ps
// ============================================================================
// Bench: partner, design and a cycle model compared every cycle
// ============================================================================
module tb_top;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic run = 1'b0;
  logic strap = 1'b0;
  logic drive_en_n = 1'b0;
  logic qn;
  psc_pkg::psc_ctrl_t ctrl;
  logic [psc_pkg::DATA_W-1:0] din;
  logic [psc_pkg::LANES-1:0] pin;
  psc_pkg::psc_write_t write_req;
  psc_pkg::psc_write_t e_wreq;
  logic write_valid, read_valid, selected, data_lane_oe, interleaved;
  logic [psc_pkg::ADDR_W-1:0] read_address, base, wa, e_addr;
  logic [psc_pkg::LANES-1:0] wl;
  logic [1:0] off;
  logic e_sel, e_wv, e_rv, sel, e_oe, emerge;
  int st, cnt;
  int err_total = 0;
  int cmp_count = 0;
  int cycles = 0;

  always #5 clk = ~clk;

  psc_ctrl_model partner (.clk(clk), .run(run), .clock_qualifier_n(qn), .ctrl(ctrl), .data_out(din),
    .parity_out(pin));
  psc_ctrl DUT (.clk(clk), .reset_n(reset_n), .clock_qualifier_n(qn), .ctrl(ctrl), .burst_order_strap(strap),
    .output_drive_enable_n(drive_en_n), .data_lane_bits_in(din), .parity_lane_bits_in(pin),
    .write_req(write_req), .write_valid(write_valid), .read_address(read_address), .read_valid(read_valid),
    .selected(selected), .data_lane_oe(data_lane_oe), .interleaved(interleaved));

  task automatic check(input string what, input logic [63:0] exp, input logic [63:0] got);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic summarize();
    if (err_total == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // ==========================================================================
  // Cycle model: state 0 deselected, 1 read, 2 write
  // ==========================================================================
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st = 0;
      cnt = 0;
      base = '0;
      e_addr = '0;
      e_sel = 1'b0;
      e_wv = 1'b0;
      e_rv = 1'b0;
      e_oe = 1'b0;
      emerge = 1'b0;
    end else begin
      e_wv = 1'b0;
      e_rv = 1'b0;
      if (!qn) begin
        e_rv = (st == 1);
        e_wv = (st == 2);
        if (st == 2) begin
          e_wreq = {wa, wl, din, pin};
        end
        // The address shown after an edge is the burst address held before it.
        off = strap ? base[1:0] ^ 2'(cnt) : base[1:0] + 2'(cnt);
        e_addr = {base[psc_pkg::ADDR_W-1:2], off};
        sel = !ctrl.chip_select_one_n && ctrl.chip_select_two && !ctrl.chip_select_three_n;
        e_oe = !drive_en_n && st == 1 && !emerge && sel && ctrl.write_strobe_n;
        emerge = sel && st == 0;
        if (ctrl.advance_or_load) begin
          cnt++;
        end else begin
          base = ctrl.address;
          cnt = 0;
        end
        if (!sel) begin
          st = 0;
        end else if (!ctrl.advance_or_load) begin
          st = ctrl.write_strobe_n ? 1 : 2;
          wa = ctrl.address;
          wl = ~ctrl.byte_lane_write_selects;
        end
        e_sel = sel;
      end else begin
        e_oe = e_oe && !drive_en_n;
      end
    end
  end

  always @(negedge clk) begin
    if (run) begin
      check("selected", 64'(e_sel), 64'(selected));
      check("write_valid", 64'(e_wv), 64'(write_valid));
      check("read_valid", 64'(e_rv), 64'(read_valid));
      check("read_address", 64'(e_addr), 64'(read_address));
      check("interleaved", 64'(strap), 64'(interleaved));
      if (e_wv) begin
        check("write_req", 64'(e_wreq), 64'(write_req));
      end
      check("data_lane_oe", 64'(e_oe), 64'(data_lane_oe));
      if (!e_sel) begin
        check("data_lane_oe", 64'h0, 64'(data_lane_oe));
      end
    end
  end

  always @(posedge clk) begin
    drive_en_n <= ($urandom % 8 == 0);
    cycles++;
    if (cycles == 8000) begin
      err_total++;
      summarize();
    end
  end

  // Second pass resets mid-run and flips the burst order strap.
  initial begin
    void'($urandom(20440));
    for (int p = 0; p < 2; p++) begin
      run <= 1'b0;
      reset_n <= 1'b0;
      strap <= p[0];
      repeat (20) @(posedge clk);
      reset_n <= 1'b1;
      repeat (5) @(posedge clk);
      run <= 1'b1;
      repeat (3000) @(posedge clk);
    end
    summarize();
  end
endmodule // tb_top
